// ### pkg/itfd_pkg.sv
// Package for the input terminal function decoder: codes, offsets, struct
`default_nettype none
package itfd_pkg;
    localparam int unsigned NUM_TERM = 10;
    localparam int unsigned HS_TERM = 9;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned CNT_W = 16;
    localparam logic [CODE_W-1:0] FN_NONE = 6'h00;
    localparam logic [CODE_W-1:0] FN_ACC_HOLD = 6'h15;
    localparam logic [CODE_W-1:0] FN_PID_PAUSE = 6'h16;
    localparam logic [CODE_W-1:0] FN_SEQ_RESET = 6'h17;
    localparam logic [CODE_W-1:0] FN_SWING_PAUSE = 6'h18;
    localparam logic [CODE_W-1:0] FN_EVT_COUNT = 6'h19;
    localparam logic [CODE_W-1:0] FN_EVT_CLEAR = 6'h1a;
    localparam logic [CODE_W-1:0] FN_LEN_COUNT = 6'h1b;
    localparam logic [CODE_W-1:0] FN_LEN_CLEAR = 6'h1c;
    localparam logic [CODE_W-1:0] FN_TRQ_BLOCK = 6'h1d;
    localparam logic [CODE_W-1:0] FN_PULSE_IN = 6'h1e;
    localparam logic [CODE_W-1:0] FN_DC_BRAKE = 6'h20;
    localparam logic [CODE_W-1:0] FN_EXT_FAULT = 6'h21;
    localparam logic [CODE_W-1:0] FN_FREF_LOCK = 6'h22;
    localparam logic [CODE_W-1:0] FN_PID_INVERT = 6'h23;
    localparam logic [CODE_W-1:0] FN_PANEL_STOP = 6'h24;
    localparam logic [CODE_W-1:0] FN_SRC_COMM = 6'h25;
    localparam logic [CODE_W-1:0] FN_INT_PAUSE = 6'h26;
    localparam logic [CODE_W-1:0] FN_MOTOR_SEL = 6'h29;
    localparam logic [CODE_W-1:0] FN_PID_SET = 6'h2b;
    localparam logic [CODE_W-1:0] FN_MODE_SWAP = 6'h2e;
    localparam logic [CODE_W-1:0] FN_ESTOP = 6'h2f;
    localparam logic [CODE_W-1:0] FN_STOP_DEC4 = 6'h30;
    localparam logic [CODE_W-1:0] FN_DEC_BRAKE = 6'h31;
    localparam logic [CODE_W-1:0] FN_RUNTIME_CLR = 6'h32;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_EVT_CNT = 32'h0000_0008;
    localparam logic [31:0] ADDR_LEN_CNT = 32'h0000_000c;
    localparam logic [31:0] ADDR_CODE_BASE = 32'h0000_0010;
    localparam logic [31:0] CODE_BASE_IDX = 32'h0000_0004;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned CTRL_PIDSW_BIT = 2;
    localparam int unsigned CTRL_TRQ_BIT = 3;
    localparam logic [1:0] SRC_PANEL = 2'h0;
    localparam logic [1:0] SRC_TERM = 2'h1;
    localparam logic [1:0] SRC_COMM = 2'h2;
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // Decoded drive actions, each a level but edge-set dc_brake_now, estop and dec_brake, the one-cycle runtime_clr pulse and ext_fault, latched until reset
    typedef struct packed {
        logic freq_hold;
        logic pid_pause;
        logic seq_reset;
        logic swing_pause;
        logic torque_block;
        logic pulse_mode;
        logic dc_brake_now;
        logic ext_fault;
        logic fref_lock;
        logic pid_invert;
        logic panel_stop;
        logic int_pause;
        logic motor2_sel;
        logic pid_set2;
        logic torque_mode;
        logic estop;
        logic stop_dec4;
        logic dec_brake;
        logic runtime_clr;
    } itfd_act_t;
    localparam int unsigned ACT_W = 19;
endpackage : itfd_pkg
`default_nettype wire

// ### rtl/itfd_top.sv
// Input terminal function decoder with APB register access
`default_nettype none
module itfd_top #(
    parameter int unsigned NUM_TERM = itfd_pkg::NUM_TERM
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [NUM_TERM-1:0] i_term,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output itfd_pkg::itfd_act_t o_act,
    output logic [1:0] o_cmd_src,
    output logic [itfd_pkg::CNT_W-1:0] o_evt_cnt,
    output logic [itfd_pkg::CNT_W-1:0] o_len_cnt
);
    localparam int unsigned CW = itfd_pkg::CODE_W;
    localparam int unsigned NW = itfd_pkg::CNT_W;
    localparam int unsigned NCODE = 1 << CW;

    logic [NUM_TERM-1:0] sync1_q;
    logic [NUM_TERM-1:0] sync2_q;
    logic [NUM_TERM-1:0] prev_q;
    logic [CW-1:0] code_q [NUM_TERM];
    logic [3:0] ctrl_q;
    logic [1:0] src_q;
    logic [NW-1:0] evt_q;
    logic [NW-1:0] len_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    itfd_pkg::itfd_act_t act_q;
    itfd_pkg::itfd_act_t act_d;

    // Terminal synchroniser, two stages
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= i_term;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    wire logic [NUM_TERM-1:0] rise = sync2_q & ~prev_q;

    // Per-function level and rising masks
    logic [NUM_TERM-1:0] lv [NCODE];
    logic [NUM_TERM-1:0] rs [NCODE];
    genvar gc, gt;
    generate
        for (gc = 0; gc < NCODE; gc++) begin : g_code
            for (gt = 0; gt < NUM_TERM; gt++) begin : g_term
                // Pulse code only on fast terminal
                wire logic ok = (gc != int'(itfd_pkg::FN_PULSE_IN)) ||
                    (gt == int'(itfd_pkg::HS_TERM));
                assign lv[gc][gt] = ok && sync2_q[gt] &&
                    (code_q[gt] == CW'(gc));
                assign rs[gc][gt] = ok && rise[gt] &&
                    (code_q[gt] == CW'(gc));
            end
        end
    endgenerate

    // APB decode; writes land at the edge that sees pready
    wire logic acc = i_psel && i_penable && !pready_q;
    wire logic wr = i_psel && i_penable && pready_q && i_pwrite;
    wire logic [31:0] code_idx = (i_paddr >> 2) - itfd_pkg::CODE_BASE_IDX;
    wire logic code_hit = (i_paddr >= itfd_pkg::ADDR_CODE_BASE) &&
        (code_idx < NUM_TERM) && (i_paddr[1:0] == 2'h0);
    wire logic ctrl_hit = i_paddr == itfd_pkg::ADDR_CTRL;
    wire logic mapped = ctrl_hit || code_hit ||
        i_paddr == itfd_pkg::ADDR_STATUS ||
        i_paddr == itfd_pkg::ADDR_EVT_CNT ||
        i_paddr == itfd_pkg::ADDR_LEN_CNT;
    wire logic cfg_trq = ctrl_q[itfd_pkg::CTRL_TRQ_BIT];
    wire logic [31:0] rd_mux =
        ctrl_hit ? {28'h000_0000, ctrl_q} :
        (i_paddr == itfd_pkg::ADDR_STATUS) ?
            {11'h000, act_q, src_q} :
        (i_paddr == itfd_pkg::ADDR_EVT_CNT) ? {16'h0000, evt_q} :
        (i_paddr == itfd_pkg::ADDR_LEN_CNT) ? {16'h0000, len_q} :
        code_hit ? {26'h000_0000, code_q[code_idx[3:0]]} :
        itfd_pkg::DATA_ZERO;

    // Bus answer one cycle into access phase
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= itfd_pkg::DATA_ZERO;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && !mapped;
            prdata_q <= (acc && !i_pwrite) ? rd_mux : itfd_pkg::DATA_ZERO;
        end
    end

    // Function code table, zero means no function
    always_ff @(posedge i_core_clk) begin
        for (int t = 0; t < NUM_TERM; t++) begin
            if (i_rst) begin
                code_q[t] <= itfd_pkg::FN_NONE;
            end else if (wr && code_hit && code_idx[3:0] == 4'(t)) begin
                code_q[t] <= i_pwdata[CW-1:0];
            end
        end
    end

    // Control register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_q <= itfd_pkg::CTRL_RST;
        end else if (wr && ctrl_hit) begin
            ctrl_q <= i_pwdata[3:0];
        end
    end

    // Event and length counters; clear wins
    wire logic evt_inc = |rs[itfd_pkg::FN_EVT_COUNT];
    wire logic evt_clr = |lv[itfd_pkg::FN_EVT_CLEAR];
    wire logic len_inc = |rs[itfd_pkg::FN_LEN_COUNT];
    wire logic len_clr = |lv[itfd_pkg::FN_LEN_CLEAR];
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            evt_q <= itfd_pkg::CNT_ZERO;
            len_q <= itfd_pkg::CNT_ZERO;
        end else begin
            evt_q <= evt_clr ? itfd_pkg::CNT_ZERO :
                evt_inc ? evt_q + itfd_pkg::CNT_ONE : evt_q;
            len_q <= len_clr ? itfd_pkg::CNT_ZERO :
                len_inc ? len_q + itfd_pkg::CNT_ONE : len_q;
        end
    end

    // Command source: config write loads, terminal switches
    wire logic to_comm = (|rs[itfd_pkg::FN_SRC_COMM]) &&
        src_q == itfd_pkg::SRC_TERM;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            src_q <= itfd_pkg::SRC_TERM;
        end else if (to_comm) begin
            src_q <= itfd_pkg::SRC_COMM;
        end else if (wr && ctrl_hit) begin
            src_q <= i_pwdata[itfd_pkg::CTRL_SRC_LSB +: 2];
        end
    end

    // Unlisted codes ignored
    // Action decode; unlisted codes drive no action
    always_comb begin
        act_d = act_q;
        act_d.freq_hold = |lv[itfd_pkg::FN_ACC_HOLD];
        act_d.pid_pause = |lv[itfd_pkg::FN_PID_PAUSE];
        act_d.seq_reset = |lv[itfd_pkg::FN_SEQ_RESET];
        act_d.swing_pause = |lv[itfd_pkg::FN_SWING_PAUSE];
        act_d.torque_block = |lv[itfd_pkg::FN_TRQ_BLOCK];
        act_d.pulse_mode = |lv[itfd_pkg::FN_PULSE_IN];
        act_d.dc_brake_now = (|rs[itfd_pkg::FN_DC_BRAKE]) ||
            (act_q.dc_brake_now && |lv[itfd_pkg::FN_DC_BRAKE]);
        act_d.ext_fault = act_q.ext_fault || |rs[itfd_pkg::FN_EXT_FAULT];
        act_d.fref_lock = |lv[itfd_pkg::FN_FREF_LOCK];
        act_d.pid_invert = |lv[itfd_pkg::FN_PID_INVERT];
        act_d.panel_stop = (|lv[itfd_pkg::FN_PANEL_STOP]) &&
            src_q == itfd_pkg::SRC_PANEL;
        act_d.int_pause = |lv[itfd_pkg::FN_INT_PAUSE];
        act_d.motor2_sel = |lv[itfd_pkg::FN_MOTOR_SEL];
        act_d.pid_set2 = ctrl_q[itfd_pkg::CTRL_PIDSW_BIT] &&
            |lv[itfd_pkg::FN_PID_SET];
        act_d.torque_mode = (cfg_trq ^ |lv[itfd_pkg::FN_MODE_SWAP]) &&
            !act_d.torque_block;
        act_d.estop = (|rs[itfd_pkg::FN_ESTOP]) ||
            (act_q.estop && |lv[itfd_pkg::FN_ESTOP]);
        act_d.stop_dec4 = |lv[itfd_pkg::FN_STOP_DEC4];
        act_d.dec_brake = (|rs[itfd_pkg::FN_DEC_BRAKE]) ||
            (act_q.dec_brake && |lv[itfd_pkg::FN_DEC_BRAKE]);
        act_d.runtime_clr = |rs[itfd_pkg::FN_RUNTIME_CLR];
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            act_q <= '0;
        end else begin
            act_q <= act_d;
        end
    end

    assign o_act = act_q;
    assign o_cmd_src = src_q;
    assign o_evt_cnt = evt_q;
    assign o_len_cnt = len_q;
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // Assertions on counters, latches, source and bus answer
    property p_evt_inc;
        @(posedge i_core_clk) disable iff (i_rst)
        (evt_inc && !evt_clr) |=>
            (evt_q == $past(evt_q) + itfd_pkg::CNT_ONE);
    endproperty
    a_evt_inc: assert property (p_evt_inc)
        else $error("event count miss");
    property p_evt_clr;
        @(posedge i_core_clk) disable iff (i_rst)
        evt_clr |=> (evt_q == itfd_pkg::CNT_ZERO);
    endproperty
    a_evt_clr: assert property (p_evt_clr)
        else $error("event count not cleared");
    property p_len_clr;
        @(posedge i_core_clk) disable iff (i_rst)
        len_clr |=> (len_q == itfd_pkg::CNT_ZERO);
    endproperty
    a_len_clr: assert property (p_len_clr)
        else $error("length not cleared");
    property p_trq;
        @(posedge i_core_clk) disable iff (i_rst)
        act_q.torque_block |-> !act_q.torque_mode;
    endproperty
    a_trq: assert property (p_trq)
        else $error("torque not blocked");
    property p_fault;
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(act_q.ext_fault) |=> act_q.ext_fault [*4];
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault dropped");
    property p_fault_set;
        @(posedge i_core_clk) disable iff (i_rst)
        (|rs[itfd_pkg::FN_EXT_FAULT]) |=> act_q.ext_fault;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault not raised");
    property p_dc_now;
        @(posedge i_core_clk) disable iff (i_rst)
        (|rs[itfd_pkg::FN_DC_BRAKE]) |=> act_q.dc_brake_now;
    endproperty
    a_dc_now: assert property (p_dc_now)
        else $error("dc brake not entered");
    property p_estop;
        @(posedge i_core_clk) disable iff (i_rst)
        (|rs[itfd_pkg::FN_ESTOP]) |=> act_q.estop;
    endproperty
    a_estop: assert property (p_estop)
        else $error("emergency stop missed");
    property p_dec_brake;
        @(posedge i_core_clk) disable iff (i_rst)
        (|rs[itfd_pkg::FN_DEC_BRAKE]) |=> act_q.dec_brake;
    endproperty
    a_dec_brake: assert property (p_dec_brake)
        else $error("decel brake missed");
    property p_pulse;
        @(posedge i_core_clk) disable iff (i_rst)
        act_q.pulse_mode |->
            $past(code_q[itfd_pkg::HS_TERM]) == itfd_pkg::FN_PULSE_IN;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulse mode off fast terminal");
    property p_comm;
        @(posedge i_core_clk) disable iff (i_rst)
        to_comm |=> (o_cmd_src == itfd_pkg::SRC_COMM);
    endproperty
    a_comm: assert property (p_comm)
        else $error("source not comm");
    property p_panel;
        @(posedge i_core_clk) disable iff (i_rst)
        act_q.panel_stop |-> $past(src_q) == itfd_pkg::SRC_PANEL;
    endproperty
    a_panel: assert property (p_panel)
        else $error("panel stop wrong");
    property p_pidset;
        @(posedge i_core_clk) disable iff (i_rst)
        act_q.pid_set2 |-> $past(ctrl_q[itfd_pkg::CTRL_PIDSW_BIT]);
    endproperty
    a_pidset: assert property (p_pidset)
        else $error("pid set wrong");
    property p_rtclr;
        @(posedge i_core_clk) disable iff (i_rst)
        act_q.runtime_clr |=> !act_q.runtime_clr;
    endproperty
    a_rtclr: assert property (p_rtclr)
        else $error("clear not pulse");
    property p_ready;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_psel && !i_penable) ##1 (i_psel && i_penable) |=> o_pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no pready");
    c_evt: cover property (@(posedge i_core_clk) evt_inc);
    c_fault: cover property (@(posedge i_core_clk) $rose(act_q.ext_fault));
    c_comm: cover property (@(posedge i_core_clk) to_comm);
    c_dc: cover property (@(posedge i_core_clk) $rose(act_q.dc_brake_now));
    c_pulse: cover property (@(posedge i_core_clk) act_q.pulse_mode);
endmodule : itfd_top
`default_nettype wire

// ### testbench/itfd_contacts.sv
// Switch contacts wired to the drive input terminals
`default_nettype none
module itfd_contacts #(
    parameter int unsigned NUM_TERM = 10
) (
    input wire logic i_core_clk,
    input wire logic [NUM_TERM-1:0] i_close,
    output logic [NUM_TERM-1:0] o_term
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts settle one edge after the bench asks
    always @(posedge i_core_clk) begin
        o_term <= i_close;
    end
endmodule : itfd_contacts
`default_nettype wire

// ### testbench/itfd_top_bench.sv
// Self-checking bench for the input terminal function decoder
`default_nettype none
module itfd_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic i_core_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [31:0] i_paddr, i_pwdata, o_prdata, rd, ca;
    logic [itfd_pkg::NUM_TERM-1:0] want, term;
    itfd_pkg::itfd_act_t o_act, e;
    logic [1:0] o_cmd_src;
    logic [15:0] o_evt_cnt, o_len_cnt;
    logic err;
    logic [5:0] codes [21];
    int n_fail, checks_done, cycles, pulses, i, k, t;

    itfd_contacts #(.NUM_TERM(itfd_pkg::NUM_TERM)) i_sw (
        .i_core_clk(i_core_clk), .i_close(want), .o_term(term));
    itfd_top i_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_term(term),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_act(o_act),
        .o_cmd_src(o_cmd_src), .o_evt_cnt(o_evt_cnt), .o_len_cnt(o_len_cnt));

    // Clock, 4 ns period
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // Cycle ceiling and run-time clear pulse count
    always @(posedge i_core_clk) begin
        cycles++;
        if (!i_rst && o_act.runtime_clr === 1'b1) pulses++;
        if (cycles == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] s, input logic [31:0] x,
                         input string m);
        checks_done++;
        if (s !== x) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, s, x);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // One idle edge before any next setup
        @(posedge i_core_clk);
        check(32'(n < 20), 32'h1, "no ready");
    endtask : apb

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] x,
                          input string m);
        apb(1'b0, a, itfd_pkg::DATA_ZERO);
        check(rd, x, m);
    endtask : rd_chk

    task automatic set_code(input int n, input logic [5:0] c);
        apb(1'b1, itfd_pkg::ADDR_CODE_BASE + 32'(4 * n), {26'h0, c});
        rd_chk(itfd_pkg::ADDR_CODE_BASE + 32'(4 * n), {26'h0, c}, "code");
    endtask : set_code

    // Contact, sync and output stages need four edges; eight leave margin
    task automatic press(input int n, input logic on);
        want[n] <= on;
        repeat (8) @(posedge i_core_clk);
    endtask : press

    function automatic itfd_pkg::itfd_act_t exp_act(input logic [5:0] c,
                                                    input int n);
        itfd_pkg::itfd_act_t a;
        a = '0;
        case (c)
            itfd_pkg::FN_ACC_HOLD: a.freq_hold = 1'b1;
            itfd_pkg::FN_PID_PAUSE: a.pid_pause = 1'b1;
            itfd_pkg::FN_SEQ_RESET: a.seq_reset = 1'b1;
            itfd_pkg::FN_SWING_PAUSE: a.swing_pause = 1'b1;
            itfd_pkg::FN_TRQ_BLOCK: a.torque_block = 1'b1;
            itfd_pkg::FN_PULSE_IN: a.pulse_mode = (n == itfd_pkg::HS_TERM);
            itfd_pkg::FN_DC_BRAKE: a.dc_brake_now = 1'b1;
            itfd_pkg::FN_FREF_LOCK: a.fref_lock = 1'b1;
            itfd_pkg::FN_PID_INVERT: a.pid_invert = 1'b1;
            itfd_pkg::FN_PANEL_STOP: a.panel_stop = 1'b1;
            itfd_pkg::FN_INT_PAUSE: a.int_pause = 1'b1;
            itfd_pkg::FN_MOTOR_SEL: a.motor2_sel = 1'b1;
            itfd_pkg::FN_PID_SET: a.pid_set2 = 1'b1;
            itfd_pkg::FN_MODE_SWAP: a.torque_mode = 1'b1;
            itfd_pkg::FN_ESTOP: a.estop = 1'b1;
            itfd_pkg::FN_STOP_DEC4: a.stop_dec4 = 1'b1;
            itfd_pkg::FN_DEC_BRAKE: a.dec_brake = 1'b1;
            default: a = '0;
        endcase
        return a;
    endfunction : exp_act

    // Main sequence
    initial begin
        i_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = '0;
        i_pwdata = '0;
        want = '0;
        codes = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h1d, 6'h20, 6'h22, 6'h23,
                  6'h24, 6'h26, 6'h29, 6'h2b, 6'h2e, 6'h2f, 6'h30, 6'h31,
                  6'h1f, 6'h2c, 6'h00, 6'h1e, 6'h1e};
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        rd_chk(itfd_pkg::ADDR_CTRL, 32'h1, "ctrl reset");
        rd_chk(itfd_pkg::ADDR_STATUS, 32'h1, "status reset");
        rd_chk(32'h0000_0080, itfd_pkg::DATA_ZERO, "unmapped read");
        check(32'(err), 32'h1, "unmapped error");
        apb(1'b1, 32'h0000_0080, 32'hffff_ffff);
        rd_chk(itfd_pkg::ADDR_CTRL, 32'h1, "ctrl after bad write");
        $display("test registers done");
        apb(1'b1, itfd_pkg::ADDR_CTRL, 32'h4);
        for (i = 0; i < 21; i++) begin
            t = (i == 20) ? itfd_pkg::HS_TERM : i % 9;
            e = exp_act(codes[i], t);
            set_code(t, codes[i]);
            press(t, 1'b1);
            check(32'(o_act), 32'(e), "level on");
            rd_chk(itfd_pkg::ADDR_STATUS, {11'h0, e, 2'h0}, "st");
            press(t, 1'b0);
            check(32'(o_act), 32'h0, "level off");
            set_code(t, itfd_pkg::FN_NONE);
        end
        $display("test level codes done");
        set_code(4, itfd_pkg::FN_RUNTIME_CLR);
        k = pulses;
        press(4, 1'b1);
        press(4, 1'b0);
        check(32'(pulses - k), 32'h1, "one clear pulse");
        set_code(4, itfd_pkg::FN_NONE);
        for (k = 0; k < 2; k++) begin
            ca = itfd_pkg::ADDR_EVT_CNT + 32'(4 * k);
            set_code(2 * k, k ? itfd_pkg::FN_LEN_COUNT :
                                itfd_pkg::FN_EVT_COUNT);
            set_code(2 * k + 1, k ? itfd_pkg::FN_LEN_CLEAR :
                                    itfd_pkg::FN_EVT_CLEAR);
            repeat (3) begin
                press(2 * k, 1'b1);
                press(2 * k, 1'b0);
            end
            check(32'(k ? o_len_cnt : o_evt_cnt), 32'h3, "count");
            press(2 * k + 1, 1'b1);
            press(2 * k, 1'b1);
            press(2 * k, 1'b0);
            rd_chk(ca, 32'h0, "cl");
            press(2 * k + 1, 1'b0);
            press(2 * k, 1'b1);
            press(2 * k, 1'b0);
            rd_chk(ca, 32'h1, "c1");
            set_code(2 * k, itfd_pkg::FN_NONE);
            set_code(2 * k + 1, itfd_pkg::FN_NONE);
        end
        $display("test counters done");
        apb(1'b1, itfd_pkg::ADDR_CTRL, 32'h1);
        set_code(5, itfd_pkg::FN_SRC_COMM);
        press(5, 1'b1);
        check(32'(o_cmd_src), 32'h2, "to comm");
        rd_chk(itfd_pkg::ADDR_STATUS, 32'h2, "status src");
        set_code(5, itfd_pkg::FN_PANEL_STOP);
        check(32'(o_act.panel_stop), 32'h0, "panel off src");
        set_code(5, itfd_pkg::FN_PID_SET);
        check(32'(o_act.pid_set2), 32'h0, "pid sw off");
        press(5, 1'b0);
        set_code(5, itfd_pkg::FN_NONE);
        apb(1'b1, itfd_pkg::ADDR_CTRL, 32'h8);
        set_code(6, itfd_pkg::FN_MODE_SWAP);
        set_code(7, itfd_pkg::FN_TRQ_BLOCK);
        check(32'(o_act.torque_mode), 32'h1, "configured");
        press(6, 1'b1);
        check(32'(o_act.torque_mode), 32'h0, "swapped");
        press(6, 1'b0);
        press(7, 1'b1);
        check(32'(o_act.torque_mode), 32'h0, "blocked");
        check(32'(o_act.torque_block), 32'h1, "block on");
        press(7, 1'b0);
        $display("test source and mode done");
        set_code(8, itfd_pkg::FN_EXT_FAULT);
        press(8, 1'b1);
        press(8, 1'b0);
        check(32'(o_act.ext_fault), 32'h1, "fault held");
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        check(32'(o_act), 32'h0, "act after reset");
        check(32'(o_cmd_src), 32'h1, "src after reset");
        $display("test fault done");
        give_verdict();
    end
endmodule : itfd_top_bench
`default_nettype wire
